// *** src/bplc_top.sv ***
// bplc_top: upper power and link control fields (bits 22:10) of the general control word.
// assumes a configuration write port of one 32-bit word, reads combinational.
`timescale 1ns/100ps
`default_nettype none
module bplc_top
  import bplc_pkg::*;
(
  // clock and resets
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                aux_rst_n_i,
  // configuration access to the general control word
  input  wire logic                cfg_wr_i,
  input  wire logic [31:0]         cfg_wdata_i,
  output logic [31:0]              cfg_rdata_o,
  // slot power
  input  wire logic                limit_msg_i,
  input  wire logic [15:0]         slot_limit_i,
  input  wire logic [15:0]         power_needed_i,
  input  wire logic [NUM_CLK-1:0]  clock_mask_i,
  input  wire logic [NUM_CLK-1:0]  clock_disable_i,
  // transaction classification
  input  wire logic                req_valid_i,
  input  wire logic                req_is_cfg_i,
  input  wire logic                req_is_limit_msg_i,
  input  wire logic                rd_valid_i,
  input  wire logic [1:0]          rd_kind_i,
  // power state and wake
  input  wire logic                in_d3_i,
  input  wire logic                in_l2_i,
  input  wire logic                wake_req_i,
  // outputs
  output logic                     power_limit_alert_pin_o,
  output logic [NUM_CLK-1:0]       sec_clk_en_o,
  output logic                     req_unsupported_o,
  output logic                     rd_prefetch_o,
  output logic                     rd_auto_prefetch_o,
  output logic [2:0]               advertised_standby_exit_latency_o,
  output logic [2:0]               advertised_deep_idle_exit_latency_o,
  output logic                     wake_o,
  output logic                     beacon_o
);

  // rd_kind_i codes: 0 plain read, 1 read line, 2 read multiple
  localparam logic [1:0] RD_PLAIN = 2'h0;

  logic [2:0] slot_power_action_sel_q;
  logic       plain_read_prefetch_off_q;
  logic [2:0] standby_exit_latency_field_q;
  logic [2:0] deep_idle_exit_latency_field_q;
  logic       secondary_clock_stop_in_d3;
  logic       beacon_enable;
  logic       reeval_q;
  logic       pin_act;
  logic       gate_act;
  logic       ur_act;
  logic [NUM_CLK-1:0] clk_en_q;
  logic       ur_q;
  logic       pref_q;
  logic       auto_q;
  logic       wake_q;
  logic       beacon_q;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      slot_power_action_sel_q        <= ACT_RST;
      plain_read_prefetch_off_q      <= 1'b0;
      standby_exit_latency_field_q   <= LAT_RST;
      deep_idle_exit_latency_field_q <= LAT_RST;
      reeval_q                       <= 1'b0;
    end else begin
      if (cfg_wr_i) begin
        slot_power_action_sel_q        <= cfg_wdata_i[ACT_HI:ACT_LO];
        plain_read_prefetch_off_q      <= cfg_wdata_i[PREF_OFF_BIT];
        standby_exit_latency_field_q   <= cfg_wdata_i[L0S_HI:L0S_LO];
        deep_idle_exit_latency_field_q <= cfg_wdata_i[L1_HI:L1_LO];
      end
      reeval_q <= cfg_wr_i || limit_msg_i;
    end
  end

  bplc_sticky u_sticky (
    .core_clk_i  (core_clk_i),
    .aux_rst_n_i (aux_rst_n_i),
    .wr_i        (cfg_wr_i),
    .d3_stop_i   (cfg_wdata_i[D3_STOP_BIT]),
    .beacon_i    (cfg_wdata_i[BEACON_BIT]),
    .d3_stop_o   (secondary_clock_stop_in_d3),
    .beacon_o    (beacon_enable)
  );

  bplc_override u_ovr (
    .core_clk_i              (core_clk_i),
    .reset_n_i               (reset_n_i),
    .slot_power_action_sel_i (slot_power_action_sel_q),
    .reeval_i                (reeval_q),
    .slot_limit_i            (slot_limit_i),
    .power_needed_i          (power_needed_i),
    .pin_o                   (pin_act),
    .clk_gate_o              (gate_act),
    .ur_o                    (ur_act)
  );

  // read word: bits outside 22:10 belong to other logic and read zero here
  wire [31:0] virtual_channel_struct_on = 32'h00000000;
  wire [31:0] rd_word = ({9'h000, slot_power_action_sel_q, plain_read_prefetch_off_q,
                          standby_exit_latency_field_q, deep_idle_exit_latency_field_q,
                          1'b0, secondary_clock_stop_in_d3, beacon_enable, 10'h000}
                         | virtual_channel_struct_on) & FIELD_MASK;
  assign cfg_rdata_o = rd_word;

  wire [NUM_CLK-1:0] clk_mask_eff = gate_act ? clock_mask_i : '0;
  wire               d3_stop      = secondary_clock_stop_in_d3 && in_d3_i;
  wire [NUM_CLK-1:0] clk_en_d     = ~(clock_disable_i | clk_mask_eff
                                      | {NUM_CLK{d3_stop}});
  wire               is_plain     = (rd_kind_i == RD_PLAIN);
  wire               pref_d       = rd_valid_i && !(plain_read_prefetch_off_q && is_plain);
  wire               ur_d         = req_valid_i && ur_act && !req_is_cfg_i
                                    && !req_is_limit_msg_i;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      clk_en_q <= '1;
      ur_q     <= 1'b0;
      pref_q   <= 1'b0;
      auto_q   <= 1'b0;
      wake_q   <= 1'b0;
      beacon_q <= 1'b0;
    end else begin
      clk_en_q <= clk_en_d;
      ur_q     <= ur_d;
      pref_q   <= pref_d;
      auto_q   <= pref_d;
      wake_q   <= in_l2_i && wake_req_i;
      beacon_q <= in_l2_i && wake_req_i && beacon_enable;
    end
  end

  assign power_limit_alert_pin_o             = pin_act;
  assign sec_clk_en_o                        = clk_en_q;
  assign req_unsupported_o                   = ur_q;
  assign rd_prefetch_o                       = pref_q;
  assign rd_auto_prefetch_o                  = auto_q;
  assign advertised_standby_exit_latency_o   = standby_exit_latency_field_q;
  assign advertised_deep_idle_exit_latency_o = deep_idle_exit_latency_field_q;
  assign wake_o                              = wake_q;
  assign beacon_o                            = beacon_q;

  sequence s_write_l0s;
    cfg_wr_i ##1 1'b1;
  endsequence

  a_l0s_copy: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    s_write_l0s |-> advertised_standby_exit_latency_o == $past(cfg_wdata_i[L0S_HI:L0S_LO]))
    else $error("standby latency not advertised");
  a_l1_copy: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cfg_wr_i |=> advertised_deep_idle_exit_latency_o == $past(cfg_wdata_i[L1_HI:L1_LO]))
    else $error("deep idle latency not advertised");
  a_vc_zero: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    cfg_rdata_o[VC_BIT] == 1'b0) else $error("vc enable bit reads one");
  a_plain_no_pref: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rd_valid_i && is_plain && plain_read_prefetch_off_q |=> !rd_prefetch_o && !rd_auto_prefetch_o)
    else $error("plain read prefetched while off");
  a_all_pref: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    rd_valid_i && !plain_read_prefetch_off_q |=> rd_prefetch_o)
    else $error("read not prefetched");
  a_d3_stop: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    in_d3_i && secondary_clock_stop_in_d3 |=> sec_clk_en_o == '0)
    else $error("clocks run in d3 with stop set");
  a_d3_run: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !secondary_clock_stop_in_d3 && !gate_act && clock_disable_i == '0 |=> sec_clk_en_o == '1)
    else $error("clocks stopped without cause");
  a_no_beacon: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    !beacon_enable |=> !beacon_o) else $error("beacon sent while disabled");
  a_beacon_wake: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    in_l2_i && wake_req_i && beacon_enable |=> beacon_o && wake_o)
    else $error("beacon wake missing");
  a_ur_cfg_pass: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    req_valid_i && (req_is_cfg_i || req_is_limit_msg_i) |=> !req_unsupported_o)
    else $error("config request refused");

endmodule : bplc_top
`default_nettype wire

// *** src/bplc_pkg.sv ***
// bplc_pkg: field layout, reset values and codes of the power/link control fields.
// assumes a 32-bit configuration word written whole by software or the EEPROM loader.
package bplc_pkg;

  localparam int unsigned   ACT_HI        = 22;
  localparam int unsigned   ACT_LO        = 20;
  localparam int unsigned   PREF_OFF_BIT  = 19;
  localparam int unsigned   L0S_HI        = 18;
  localparam int unsigned   L0S_LO        = 16;
  localparam int unsigned   L1_HI         = 15;
  localparam int unsigned   L1_LO         = 13;
  localparam int unsigned   VC_BIT        = 12;
  localparam int unsigned   D3_STOP_BIT   = 11;
  localparam int unsigned   BEACON_BIT    = 10;
  localparam logic [31:0]   FIELD_MASK    = 32'h007FEC00;
  localparam logic [2:0]    ACT_RST       = 3'h0;
  localparam logic [2:0]    LAT_RST       = 3'h0;
  localparam int unsigned   NUM_CLK       = 7;

  typedef enum logic [2:0] {
    BPLC_ACT_NONE  = 3'h0,
    BPLC_ACT_PIN   = 3'h1,
    BPLC_ACT_CLK   = 3'h2,
    BPLC_ACT_BOTH  = 3'h3,
    BPLC_ACT_UR    = 3'h4
  } bplc_act_t;

  typedef enum logic [1:0] {
    BPLC_ST_OK     = 2'h0,
    BPLC_ST_SHORT  = 2'h1
  } bplc_state_t;

endpackage : bplc_pkg

// *** src/bplc_sticky.sv ***
// bplc_sticky: the two bits kept across resets while on auxiliary supply.
// assumes aux_rst_n_i is the power-on reset of the auxiliary domain.
`timescale 1ns/100ps
`default_nettype none
module bplc_sticky
  import bplc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic aux_rst_n_i,
  // write
  input  wire logic wr_i,
  input  wire logic d3_stop_i,
  input  wire logic beacon_i,
  // state
  output logic      d3_stop_o,
  output logic      beacon_o
);

  logic d3_stop_q;
  logic beacon_q;

  // only power-on clears these, fundamental reset does not
  always_ff @(posedge core_clk_i) begin
    if (!aux_rst_n_i) begin
      d3_stop_q <= 1'b0;
      beacon_q  <= 1'b0;
    end else if (wr_i) begin
      d3_stop_q <= d3_stop_i;
      beacon_q  <= beacon_i;
    end
  end

  assign d3_stop_o = d3_stop_q;
  assign beacon_o  = beacon_q;

endmodule : bplc_sticky
`default_nettype wire

// *** src/bplc_override.sv ***
// bplc_override: decides the slot power limit actions from the selector.
// assumes power figures share one scale and are stable between messages.
`timescale 1ns/100ps
`default_nettype none
module bplc_override
  import bplc_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                reset_n_i,
  // selector and power figures
  input  wire logic [2:0]          slot_power_action_sel_i,
  input  wire logic                reeval_i,
  input  wire logic [15:0]         slot_limit_i,
  input  wire logic [15:0]         power_needed_i,
  // actions
  output logic                     pin_o,
  output logic                     clk_gate_o,
  output logic                     ur_o
);

  logic short_q;
  logic short_d;
  logic pin_q;
  logic gate_q;
  logic ur_q;
  wire  sel_pin  = (slot_power_action_sel_i == BPLC_ACT_PIN)
                || (slot_power_action_sel_i == BPLC_ACT_BOTH);
  wire  sel_gate = (slot_power_action_sel_i == BPLC_ACT_CLK)
                || (slot_power_action_sel_i == BPLC_ACT_BOTH);
  wire  sel_ur   = (slot_power_action_sel_i == BPLC_ACT_UR);

  // latched at each message or write, released when the limit suffices
  assign short_d = reeval_i ? (slot_limit_i < power_needed_i) : short_q;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      short_q <= 1'b0;
      pin_q   <= 1'b0;
      gate_q  <= 1'b0;
      ur_q    <= 1'b0;
    end else begin
      short_q <= short_d;
      pin_q   <= short_d && sel_pin;
      gate_q  <= short_d && sel_gate;
      ur_q    <= short_d && sel_ur;
    end
  end

  assign pin_o      = pin_q;
  assign clk_gate_o = gate_q;
  assign ur_o       = ur_q;

  a_pin_follows_sel: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    pin_o |-> $past(sel_pin) && $past(short_d)) else $error("alert pin without cause");
  a_reserved_quiet: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    $past(slot_power_action_sel_i) > 3'h4 |-> !pin_o && !clk_gate_o && !ur_o)
    else $error("reserved code acted");
  a_release_ok: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    reeval_i && !(slot_limit_i < power_needed_i) |=> !pin_o && !clk_gate_o && !ur_o)
    else $error("action kept after limit sufficient");

endmodule : bplc_override
`default_nettype wire

// *** verif/tb.sv ***
// tb: self-checking bench for the upper power/link control fields of the control word.
// assumes bplc_pkg and bplc_top are compiled first; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bplc_pkg::*;

  logic                core_clk_i;
  logic                reset_n_i;
  logic                aux_rst_n_i;
  logic                cfg_wr_i;
  logic [31:0]         cfg_wdata_i;
  logic [31:0]         cfg_rdata_o;
  logic                limit_msg_i;
  logic [15:0]         slot_limit_i;
  logic [15:0]         power_needed_i;
  logic [NUM_CLK-1:0]  clock_mask_i;
  logic [NUM_CLK-1:0]  clock_disable_i;
  logic                req_valid_i;
  logic                req_is_cfg_i;
  logic                req_is_limit_msg_i;
  logic                rd_valid_i;
  logic [1:0]          rd_kind_i;
  logic                in_d3_i;
  logic                in_l2_i;
  logic                wake_req_i;
  logic                power_limit_alert_pin_o;
  logic [NUM_CLK-1:0]  sec_clk_en_o;
  logic                req_unsupported_o;
  logic                rd_prefetch_o;
  logic                rd_auto_prefetch_o;
  logic [2:0]          advertised_standby_exit_latency_o;
  logic [2:0]          advertised_deep_idle_exit_latency_o;
  logic                wake_o;
  logic                beacon_o;
  int                  miscompares;
  int                  samples_checked;
  logic [2:0]          sel;
  logic                pin;
  logic                gate;

  bplc_top dut_u (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .aux_rst_n_i(aux_rst_n_i),
    .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .limit_msg_i(limit_msg_i), .slot_limit_i(slot_limit_i), .power_needed_i(power_needed_i),
    .clock_mask_i(clock_mask_i), .clock_disable_i(clock_disable_i),
    .req_valid_i(req_valid_i), .req_is_cfg_i(req_is_cfg_i),
    .req_is_limit_msg_i(req_is_limit_msg_i), .rd_valid_i(rd_valid_i), .rd_kind_i(rd_kind_i),
    .in_d3_i(in_d3_i), .in_l2_i(in_l2_i), .wake_req_i(wake_req_i),
    .power_limit_alert_pin_o(power_limit_alert_pin_o), .sec_clk_en_o(sec_clk_en_o),
    .req_unsupported_o(req_unsupported_o), .rd_prefetch_o(rd_prefetch_o),
    .rd_auto_prefetch_o(rd_auto_prefetch_o),
    .advertised_standby_exit_latency_o(advertised_standby_exit_latency_o),
    .advertised_deep_idle_exit_latency_o(advertised_deep_idle_exit_latency_o),
    .wake_o(wake_o), .beacon_o(beacon_o));

  // reference clock never stops; the secondary clocks stop only through sec_clk_en_o
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic final_report();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [31:0] d);
    cfg_wr_i    = 1'b1;
    cfg_wdata_i = d;
    tick();
    cfg_wr_i    = 1'b0;
  endtask : wr

  // actions land two edges after the write, clock enables one more
  task automatic settle();
    repeat (3) tick();
  endtask : settle

  task automatic msg();
    limit_msg_i = 1'b1;
    tick();
    limit_msg_i = 1'b0;
    settle();
  endtask : msg

  task automatic req(input logic cfg, input logic lim, input logic exp);
    req_valid_i        = 1'b1;
    req_is_cfg_i       = cfg;
    req_is_limit_msg_i = lim;
    tick();
    check(32'(req_unsupported_o), 32'(exp));
    // one idle edge so back-to-back calls never re-raise valid in one step
    req_valid_i        = 1'b0;
    tick();
  endtask : req

  task automatic rd(input logic [1:0] k, input logic exp);
    rd_valid_i = 1'b1;
    rd_kind_i  = k;
    tick();
    check({30'h0, rd_prefetch_o, rd_auto_prefetch_o}, {30'h0, exp, exp});
    rd_valid_i = 1'b0;
    tick();
  endtask : rd

  initial begin
    repeat (5000) @(posedge core_clk_i);
    miscompares++;
    final_report();
  end

  initial begin
    miscompares        = 0;
    samples_checked    = 0;
    reset_n_i          = 1'b0;
    aux_rst_n_i        = 1'b0;
    cfg_wr_i           = 1'b0;
    cfg_wdata_i        = 32'h0;
    limit_msg_i        = 1'b0;
    slot_limit_i       = 16'h0010;
    power_needed_i     = 16'h0020;
    clock_mask_i       = 7'h55;
    clock_disable_i    = 7'h00;
    req_valid_i        = 1'b0;
    req_is_cfg_i       = 1'b0;
    req_is_limit_msg_i = 1'b0;
    rd_valid_i         = 1'b0;
    rd_kind_i          = 2'h0;
    in_d3_i            = 1'b0;
    in_l2_i            = 1'b0;
    wake_req_i         = 1'b0;
    repeat (20) @(posedge core_clk_i);
    #1;
    reset_n_i   = 1'b1;
    aux_rst_n_i = 1'b1;
    tick();
    check(cfg_rdata_o, 32'h0);
    check({power_limit_alert_pin_o, sec_clk_en_o}, {1'b0, 7'h7F});
    // reserved bits and the hardwired channel bit never read back
    wr(32'hFFFFFFFF);
    check(cfg_rdata_o, FIELD_MASK);
    tick();
    check({advertised_standby_exit_latency_o, advertised_deep_idle_exit_latency_o}, 6'h3F);
    wr(32'h00054000);
    tick();
    check({advertised_standby_exit_latency_o, advertised_deep_idle_exit_latency_o}, 6'h2A);
    wr(32'h00000C00);
    reset_n_i = 1'b0;
    repeat (2) tick();
    reset_n_i = 1'b1;
    check(cfg_rdata_o, 32'h00000C00);
    reset_n_i   = 1'b0;
    aux_rst_n_i = 1'b0;
    repeat (2) tick();
    reset_n_i   = 1'b1;
    aux_rst_n_i = 1'b1;
    check(cfg_rdata_o, 32'h0);
    // every selector code with the limit short of the need
    for (int s = 0; s < 8; s++) begin
      sel  = s[2:0];
      wr({9'h0, sel, 20'h0});
      settle();
      pin  = (sel == 3'h1) || (sel == 3'h3);
      gate = (sel == 3'h2) || (sel == 3'h3);
      check(32'(power_limit_alert_pin_o), 32'(pin));
      check(32'(sec_clk_en_o), gate ? {25'h0, ~clock_mask_i} : 32'h7F);
      req(1'b0, 1'b0, sel == 3'h4);
      req(1'b1, 1'b0, 1'b0);
      req(1'b0, 1'b1, 1'b0);
    end
    wr(32'h00300000);
    settle();
    slot_limit_i = 16'h0020;
    msg();
    check({31'h0, power_limit_alert_pin_o}, 32'h0);
    check(32'(sec_clk_en_o), 32'h7F);
    slot_limit_i = 16'h001F;
    msg();
    check({25'h0, power_limit_alert_pin_o, sec_clk_en_o}, 32'hAA);
    // limit is only looked at on a new message or a config write
    slot_limit_i = 16'h0040;
    settle();
    check(32'(power_limit_alert_pin_o), 32'h1);
    msg();
    check(32'(power_limit_alert_pin_o), 32'h0);
    wr(32'h0);
    for (int k = 0; k < 3; k++) rd(k[1:0], 1'b1);
    wr(32'h00080000);
    rd(2'h0, 1'b0);
    rd(2'h1, 1'b1);
    rd(2'h2, 1'b1);
    in_d3_i = 1'b1;
    wr(32'h0);
    settle();
    check(32'(sec_clk_en_o), 32'h7F);
    wr(32'h00000800);
    settle();
    check(32'(sec_clk_en_o), 32'h0);
    in_d3_i    = 1'b0;
    in_l2_i    = 1'b1;
    wake_req_i = 1'b1;
    wr(32'h0);
    settle();
    check({30'h0, wake_o, beacon_o}, 32'h2);
    wr(32'h00000400);
    settle();
    check({30'h0, wake_o, beacon_o}, 32'h3);
    // selector 000: the mask stays out, only the disable register acts
    clock_disable_i = 7'h03;
    repeat (2) tick();
    check(32'(sec_clk_en_o), 32'h7C);
    final_report();
  end
endmodule : tb
`default_nettype wire
